// File: common/dcp_pkg.sv
// Shared constants and state types for the control port link.
// Assumes both ends import it whole.
package dcp_pkg;
   // Two-wire target address prefix, upper six bits
   localparam logic [5:0] DCP_ADDR_PREFIX = 6'h08;
   // Address byte that opens every SPI frame
   localparam logic [7:0] DCP_SPI_ADDR = 8'h20;
   // Pointer layout and reset value
   localparam int DCP_AUTO_BIT = 7;
   localparam int DCP_MAP_W = 4;
   localparam logic [7:0] DCP_PTR_RESET = 8'h00;
   // Host clock cycles per quarter bit of the serial clock
   localparam int DCP_DIV = 4;
   // Idle level of a released read bit
   localparam logic [7:0] DCP_TX_IDLE = 8'hFF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ = 3'b100,
      ST_MACK = 3'b101,
      ST_RNEXT = 3'b110,
      ST_IGNORE = 3'b111
   } dcp_dev_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_START = 2'b01,
      H_BIT = 2'b10,
      H_STOP = 2'b11
   } dcp_host_e;
endpackage : dcp_pkg

// File: common/dcp_link_if.sv
// Control port pins between host and device.
// The data line is open drain with a pull-up worked out here.
`timescale 1ns/1ns
interface dcp_link_if;
   logic serial_control_clock;
   logic shared_address_select_pin;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;

   // Wired-AND with pull-up: any enabled low driver wins
   assign sda = ((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o))
                ? 1'b0 : 1'b1;

   modport dev (
      input serial_control_clock, shared_address_select_pin, sda,
      output sda_dev_o, sda_dev_oe
   );
   modport host (
      output serial_control_clock, shared_address_select_pin, sda_host_o,
      output sda_host_oe,
      input sda
   );
endinterface : dcp_link_if

// File: hdl/dcp_device.sv
// Device end of the control port: two-wire target and SPI write slave.
// Assumes clk is the converter master clock, running during two-wire
// traffic, and that a register file answers rd_data for rd_addr.
// Notes on behaviour
// - Port runs unrelated to the audio sample clock
// - Host keeps port pins static when idle
// - Master clock runs throughout two-wire transfers
// - Cleared auto-increment bit keeps pointer fixed
// - Set auto-increment bit advances pointer per byte
// - Address is 001000, select pin, direction
// - Falling edge on select pin selects SPI
// - Write: address, pointer byte, then data byte
// - Host bursts only with auto-increment set
// - Read acknowledges address, sends pointed register
// - Read uses last written or reset pointer
// - Read burst continues while host acknowledges
// - Host rewrites pointer before reading elsewhere
// - SPI samples data on rising control clock
// - SPI frame: address 00100000, pointer, data
// - Host ends every SPI frame with select high
// - Pointer and auto-increment reset to zero
// - Two-wire reads and writes; SPI only writes
`timescale 1ns/1ns
module dcp_device
   import dcp_pkg::*;
#(
   parameter int MAP_W = DCP_MAP_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link pins
   dcp_link_if.dev link,
   // Register file side
   output logic reg_wr,
   output logic [MAP_W-1:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic [MAP_W-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic spi_mode
);

   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [2:0] sel_s;
   logic [2:0] tog_s;
   dcp_dev_e state;
   logic [2:0] bitcnt;
   logic [7:0] sh;
   logic rw;
   logic first;
   logic ack_drive;
   logic [7:0] tx;
   logic [7:0] ptr;
   // Link-domain SPI state
   logic lrst_n;
   logic [2:0] lbit;
   logic [6:0] lsh;
   logic [1:0] lcnt;
   logic lok;
   logic [7:0] l_byte;
   logic l_first;
   logic l_tog;

   // Pins into the clk domain; stage 0 feeds only stage 1
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         sel_s <= 3'h0;
         tog_s <= 3'h0;
      end else begin
         scl_s <= {scl_s[1:0], link.serial_control_clock};
         sda_s <= {sda_s[1:0], link.sda};
         sel_s <= {sel_s[1:0], link.shared_address_select_pin};
         tog_s <= {tog_s[1:0], l_tog};
      end
   end

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] rx_byte;
   logic addr_hit;
   logic spi_ev;
   logic i2c_byte;
   logic ptr_ld;
   logic data_wr;
   logic rd_inc;
   logic [7:0] in_byte;

   // Bus conditions seen on synchronised levels
   assign scl = scl_s[1];
   assign sda = sda_s[1];
   assign scl_rise = scl && !scl_s[2];
   assign scl_fall = !scl && scl_s[2];
   assign start_c = scl && scl_s[2] && sda_s[2] && !sda;
   assign stop_c = scl && scl_s[2] && !sda_s[2] && sda;
   assign rx_byte = {sh[6:0], sda};
   assign addr_hit = (rx_byte[7:1] == {DCP_ADDR_PREFIX, sel_s[1]});

   // Mode latch: any falling select edge moves the port to SPI for good
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         spi_mode <= 1'b0;
      end else if (sel_s[2] && !sel_s[1]) begin
         spi_mode <= 1'b1;
      end
   end

   // Two-wire target state machine, oversampled on clk
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         bitcnt <= 3'h0;
         sh <= 8'h00;
         rw <= 1'b0;
         first <= 1'b0;
         ack_drive <= 1'b0;
         tx <= DCP_TX_IDLE;
      end else if (spi_mode) begin
         // No two-wire target once the pin serves as chip select
         state <= ST_IDLE;
         ack_drive <= 1'b0;
         tx <= DCP_TX_IDLE;
      end else if (start_c) begin
         // Start and repeated start both restart address reception
         state <= ST_ADDR;
         bitcnt <= 3'h0;
         ack_drive <= 1'b0;
         tx <= DCP_TX_IDLE;
      end else if (stop_c) begin
         state <= ST_IDLE;
         ack_drive <= 1'b0;
         tx <= DCP_TX_IDLE;
      end else begin
         case (state)
            ST_ADDR: begin
               if (scl_rise) begin
                  sh <= rx_byte;
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     if (addr_hit) begin
                        rw <= rx_byte[0];
                        first <= 1'b1;
                        state <= ST_ACK;
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end
               end
            end
            ST_ACK: begin
               // First fall pulls the line low, second releases it
               if (scl_fall) begin
                  if (!ack_drive) begin
                     ack_drive <= 1'b1;
                  end else begin
                     ack_drive <= 1'b0;
                     if (rw) begin
                        tx <= rd_data;
                        state <= ST_READ;
                     end else begin
                        state <= ST_WRITE;
                     end
                  end
               end
            end
            ST_WRITE: begin
               if (scl_rise) begin
                  sh <= rx_byte;
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     first <= 1'b0;
                     state <= ST_ACK;
                  end
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  tx <= {tx[6:0], 1'b1};
               end
               if (scl_rise) begin
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     state <= ST_MACK;
                  end
               end
            end
            ST_MACK: begin
               // Release for the host's acknowledge; a high bit ends it
               if (scl_fall) begin
                  tx <= DCP_TX_IDLE;
               end
               if (scl_rise) begin
                  state <= sda ? ST_IGNORE : ST_RNEXT;
               end
            end
            ST_RNEXT: begin
               if (scl_fall) begin
                  tx <= rd_data;
                  state <= ST_READ;
               end
            end
            default: begin
               state <= state; // Idle or ignored: wait for start
            end
         endcase
      end
   end

   // Open drain: only ever pull low
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = ack_drive || !tx[7];

   // SPI bit and byte counters are held in reset while chip select is high
   assign lrst_n = reset_n && !link.shared_address_select_pin;

   // Bit and byte counting on the control clock, per frame
   always_ff @(posedge link.serial_control_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         lbit <= 3'h0;
         lsh <= 7'h00;
         lcnt <= 2'h0;
         lok <= 1'b0;
      end else begin
         lsh <= {lsh[5:0], link.sda};
         lbit <= lbit + 3'h1;
         if (lbit == 3'h7) begin
            if (lcnt == 2'h0) begin
               lok <= ({lsh, link.sda} == DCP_SPI_ADDR);
            end
            if (lcnt != 2'h2) begin
               lcnt <= lcnt + 2'h1;
            end
         end
      end
   end

   // Completed bytes leave by toggle; they hold for a whole byte time,
   // far longer than the three clk edges the receiving side needs
   always_ff @(posedge link.serial_control_clock or negedge reset_n) begin
      if (!reset_n) begin
         l_byte <= 8'h00;
         l_first <= 1'b0;
         l_tog <= 1'b0;
      end else if (link.shared_address_select_pin) begin
         l_tog <= l_tog;
      end else if (lbit == 3'h7 && lcnt != 2'h0 && lok) begin
         l_byte <= {lsh, link.sda};
         l_first <= (lcnt == 2'h1);
         l_tog <= !l_tog;
      end
   end

   // Byte events from both ports into the pointer and register writes
   assign spi_ev = spi_mode && (tog_s[2] != tog_s[1]);
   assign i2c_byte = (state == ST_WRITE) && scl_rise && (bitcnt == 3'h7);
   assign ptr_ld = (i2c_byte && first) || (spi_ev && l_first);
   assign data_wr = (i2c_byte && !first) || (spi_ev && !l_first);
   assign rd_inc = (state == ST_READ) && scl_rise && (bitcnt == 3'h7);
   assign in_byte = spi_ev ? l_byte : rx_byte;

   // Register pointer, shared by both ports
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr <= DCP_PTR_RESET;
      end else if (ptr_ld) begin
         ptr <= in_byte;
      end else if ((data_wr || rd_inc) && ptr[DCP_AUTO_BIT]) begin
         ptr[MAP_W-1:0] <= ptr[MAP_W-1:0] + 1'b1;
      end else begin
         ptr <= ptr;
      end
   end

   // Write strobe to the register file, one clk cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_wr <= 1'b0;
         reg_addr <= '0;
         reg_wdata <= 8'h00;
      end else begin
         reg_wr <= data_wr;
         if (data_wr) begin
            reg_addr <= ptr[MAP_W-1:0];
            reg_wdata <= in_byte;
         end
      end
   end

   assign rd_addr = ptr[MAP_W-1:0];
endmodule : dcp_device

// File: hdl/dcp_host.sv
// Host end of the control port: two-wire or SPI master, one command
// per transaction. Assumes the device end shares the dcp_link_if.
`timescale 1ns/1ns
module dcp_host
   import dcp_pkg::*;
#(
   parameter int DIV = DCP_DIV,
   parameter logic ADSEL = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link pins
   dcp_link_if.host link,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_spi,
   input wire logic cmd_read,
   input wire logic cmd_two,
   input wire logic [7:0] cmd_ptr,
   input wire logic [7:0] cmd_data,
   // Answer
   output logic done,
   output logic [7:0] rsp_data,
   output logic nack
);

   dcp_host_e state;
   logic [7:0] div_cnt;
   logic tick;
   logic [1:0] ph;
   logic [3:0] bitn;
   logic [1:0] idx;
   logic spi_r;
   logic read_r;
   logic two_r;
   logic [7:0] q_ptr;
   logic [7:0] q_data;
   logic [7:0] tx;
   logic [7:0] rx;
   logic reading;
   logic scl;
   logic sda_oe;
   logic sel;
   logic last_bit;
   logic last_byte;

   // Quarter-bit tick: the serial clock is divided from clk
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 8'h00;
      end else if (state == H_IDLE || tick) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign tick = (div_cnt == 8'(DIV - 1));
   assign last_bit = spi_r ? (bitn == 4'h7) : (bitn == 4'h8);
   assign last_byte = (idx == 2'h2) || (idx == 2'h1 && (read_r || !two_r));

   // Transaction sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= H_IDLE;
         ph <= 2'h0;
         bitn <= 4'h0;
         idx <= 2'h0;
         {spi_r, read_r, two_r, reading} <= 4'h0;
         q_ptr <= 8'h00;
         q_data <= 8'h00;
         tx <= 8'h00;
         rx <= 8'h00;
         scl <= 1'b1;
         sda_oe <= 1'b0;
         sel <= ADSEL;
         done <= 1'b0;
         rsp_data <= 8'h00;
         nack <= 1'b0;
      end else begin
         done <= 1'b0;
         if (state == H_IDLE) begin
            if (cmd_valid) begin
               spi_r <= cmd_spi;
               read_r <= cmd_read && !cmd_spi;
               two_r <= cmd_two;
               q_ptr <= cmd_ptr;
               q_data <= cmd_data;
               tx <= cmd_spi ? DCP_SPI_ADDR
                     : {DCP_ADDR_PREFIX, ADSEL, cmd_read};
               reading <= 1'b0;
               idx <= 2'h0;
               bitn <= 4'h0;
               ph <= 2'h0;
               nack <= 1'b0;
               state <= H_START;
            end
         end else if (tick) begin
            ph <= ph + 2'h1;
            case (state)
               H_START: begin
                  // SPI: select high then low so the device sees a fall
                  if (ph == 2'h0) begin
                     scl <= !spi_r;
                     sda_oe <= 1'b0;
                     sel <= spi_r ? 1'b1 : ADSEL;
                  end else if (ph == 2'h1) begin
                     if (spi_r) sel <= 1'b0;
                     else sda_oe <= 1'b1;
                  end else if (ph == 2'h2) begin
                     scl <= 1'b0;
                  end else begin
                     state <= H_BIT;
                  end
               end
               H_BIT: begin
                  if (ph == 2'h0) begin
                     sda_oe <= (bitn[3] || reading) ? 1'b0 : !tx[7];
                  end else if (ph == 2'h1) begin
                     scl <= 1'b1;
                  end else if (ph == 2'h2) begin
                     if (!bitn[3]) rx <= {rx[6:0], link.sda};
                     else if (!reading && link.sda) nack <= 1'b1;
                  end else begin
                     scl <= 1'b0;
                     tx <= {tx[6:0], 1'b0};
                     bitn <= bitn + 4'h1;
                     if (last_bit) begin
                        bitn <= 4'h0;
                        idx <= idx + 2'h1;
                        reading <= read_r;
                        tx <= (idx == 2'h0) ? q_ptr : q_data;
                        if (last_byte || (nack && !spi_r)) state <= H_STOP;
                        else if (!spi_r && link.sda && !reading)
                           state <= H_STOP;
                     end
                  end
               end
               default: begin
                  // Stop: data rises while clock high; SPI raises select
                  if (ph == 2'h0) begin
                     sda_oe <= !spi_r;
                  end else if (ph == 2'h1) begin
                     if (spi_r) sel <= 1'b1;
                     else scl <= 1'b1;
                  end else if (ph == 2'h2) begin
                     sda_oe <= 1'b0;
                  end else begin
                     done <= 1'b1;
                     rsp_data <= rx;
                     state <= H_IDLE;
                  end
               end
            endcase
         end
      end
   end

   assign cmd_ready = (state == H_IDLE);
   assign link.serial_control_clock = scl;
   assign link.shared_address_select_pin = sel;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = sda_oe;
endmodule : dcp_host

// File: tb/dcp_link_sva.sv
// Checker for the control port wires between host and device ends.
// Assumes clk is the master clock and the host leaves ADSEL at 1'b0.
`timescale 1ns/1ns
module dcp_link_sva
   import dcp_pkg::*;
#(
   parameter logic ADSEL = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link wires
   input wire logic serial_control_clock,
   input wire logic shared_address_select_pin,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic sda
);
   logic scl_q, sda_q, sel_q, spi_seen, first, rise, start, match;
   logic spi_frame;
   logic [3:0] bits;
   logic [7:0] addr, spi_sh;
   logic [4:0] spi_cnt;

   // Wire events seen by the master clock
   assign rise = serial_control_clock && !scl_q;
   assign start = sda_q && !sda && serial_control_clock && scl_q;
   assign match = addr[7:1] == {DCP_ADDR_PREFIX, ADSEL};

   // Delayed copies; a select fall is sticky like the device mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sel_q <= ADSEL;
         spi_seen <= 1'b0;
         spi_frame <= 1'b0;
      end else begin
         scl_q <= serial_control_clock;
         sda_q <= sda;
         sel_q <= shared_address_select_pin;
         spi_seen <= spi_seen || (sel_q && !shared_address_select_pin);
         // A select fall with the clock low opens a real SPI frame; a
         // two-wire start after SPI mode drops select with the clock high
         if (sel_q && !shared_address_select_pin)
            spi_frame <= !serial_control_clock;
      end
   end

   // Bit slot counter; slot 8 is the acknowledge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bits <= 4'h0;
         first <= 1'b0;
         addr <= 8'h00;
      end else if (start) begin
         bits <= 4'h0;
         first <= 1'b1;
      end else if (rise) begin
         bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
         if (bits == 4'h8)
            first <= 1'b0;
         else if (first)
            addr <= {addr[6:0], sda};
      end
   end

   // SPI frame shifter; select high clears it since the clock stops
   always_ff @(posedge serial_control_clock
               or posedge shared_address_select_pin) begin
      if (shared_address_select_pin) begin
         spi_cnt <= 5'h00;
         spi_sh <= 8'h00;
      end else begin
         if (spi_cnt != 5'h09)
            spi_cnt <= spi_cnt + 5'h01;
         if (spi_cnt < 5'h08)
            spi_sh <= {spi_sh[6:0], sda};
      end
   end

   chk_addr_ack: assert property (
      @(posedge clk) disable iff (!reset_n)
      rise && first && bits == 4'h8 && match && !spi_seen |-> sda_dev_oe)
      else $error("own address not acknowledged");
   chk_ack_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      rise && bits == 4'h8 && match && !addr[0] && !spi_seen
      |-> !sda [*4])
      else $error("write acknowledge not held low");
   chk_ack_release: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(sda_dev_oe) && !addr[0] |-> ##[8:40] !sda_dev_oe)
      else $error("write acknowledge not released");
   chk_dev_pulls_low: assert property (
      @(posedge clk) disable iff (!reset_n)
      sda_dev_oe |-> !sda_dev_o && !sda)
      else $error("device enable without low data line");
   chk_dev_edge: assert property (
      @(posedge clk) disable iff (!reset_n)
      $changed(sda_dev_oe) |-> !serial_control_clock)
      else $error("device changed data while clock high");
   chk_spi_silent: assert property (
      @(posedge clk) disable iff (!reset_n)
      spi_seen |-> !sda_dev_oe)
      else $error("device drove the line in SPI mode");
   chk_spi_stable: assert property (
      @(posedge clk) disable iff (!reset_n)
      spi_seen && rise |-> $stable(sda) && !sda_host_o)
      else $error("SPI data moved at the sampling edge");
   chk_spi_addr: assert property (
      @(posedge serial_control_clock) disable iff (!reset_n)
      spi_seen && spi_frame && spi_cnt == 5'h08 |-> spi_sh == DCP_SPI_ADDR)
      else $error("SPI frame opened with a wrong address byte");

   cov_addr_ack: cover property (@(posedge clk)
      rise && first && bits == 4'h8 && !sda);
   cov_read_end: cover property (@(posedge clk)
      rise && bits == 4'h8 && addr[0] && sda && sda_host_oe == 1'b0);
   cov_spi: cover property (@(posedge clk) $rose(spi_seen));
endmodule : dcp_link_sva

// File: tb/testbench.sv
// Testbench joining host and device ends over one link.
// Assumes a register file model answering the device read port.
`timescale 1ns/1ns
module testbench import dcp_pkg::*;;
   logic clk, reset_n, cmd_valid, cmd_spi, cmd_read, cmd_two;
   logic cmd_ready, done, nack, reg_wr, spi_mode;
   logic [7:0] cmd_ptr, cmd_data, rsp_data, rd_data, reg_wdata;
   logic [3:0] reg_addr, rd_addr;
   logic [7:0] regs [16];
   int fail_count = 0;
   int tests_run = 0;
   int wr_count = 0;

   dcp_link_if link ();
   dcp_host #(.DIV(DCP_DIV), .ADSEL(1'b0)) i_dcp_host (
      .clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_spi(cmd_spi), .cmd_read(cmd_read),
      .cmd_two(cmd_two), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
      .done(done), .rsp_data(rsp_data), .nack(nack));
   dcp_device #(.MAP_W(DCP_MAP_W)) i_dcp_device (
      .clk(clk), .reset_n(reset_n), .link(link), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_addr(rd_addr),
      .rd_data(rd_data), .spi_mode(spi_mode));
   dcp_link_sva #(.ADSEL(1'b0)) i_dcp_link_sva (
      .clk(clk), .reset_n(reset_n),
      .serial_control_clock(link.serial_control_clock),
      .shared_address_select_pin(link.shared_address_select_pin),
      .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
      .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
      .sda(link.sda));

   // Register file; reads answer at once, writes are counted
   assign rd_data = regs[rd_addr];
   always @(posedge clk) begin
      if (reg_wr === 1'b1) begin
         regs[reg_addr] <= reg_wdata;
         wr_count <= wr_count + 1;
      end
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One host command; bounded wait for its done pulse
   task automatic run(input logic spi, rd, two, input logic [7:0] ptr, dat);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      {cmd_valid, cmd_spi, cmd_read, cmd_two} = {1'b1, spi, rd, two};
      {cmd_ptr, cmd_data} = {ptr, dat};
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 4000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (done !== 1'b1) begin
         fail_count++;
         $display("[FAIL] done expected 1 seen %b", done);
         give_verdict();
      end
      chk("ready", 8'h01, {7'h00, cmd_ready});
   endtask : run

   // SPI writes land after the clock crossing, so wait bounded
   task automatic wait_wr(input int n);
      for (int i = 0; i < 200 && wr_count != n; i++)
         @(posedge clk);
      chk("write count", 8'(n), 8'(wr_count));
   endtask : wait_wr

   task automatic read_chk(input logic [7:0] exp);
      run(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
      chk("read data", exp, rsp_data);
      chk("read nack", 8'h00, {7'h00, nack});
   endtask : read_chk

   initial begin
      {reset_n, cmd_valid, cmd_spi, cmd_read, cmd_two} = 5'h00;
      {cmd_ptr, cmd_data} = 16'h0000;
      for (int i = 0; i < 16; i++)
         regs[i] = 8'hA0 + 8'(i);
      repeat (16) @(posedge clk);
      #1 reset_n = 1'b1;
      chk("pointer", 8'h00, {4'h0, rd_addr});
      chk("spi mode", 8'h00, {7'h00, spi_mode});
      read_chk(8'hA0);
      $display("test reset and first read finished");
      run(1'b0, 1'b0, 1'b1, 8'h03, 8'h5C);
      wait_wr(1);
      chk("reg 3", 8'h5C, regs[3]);
      read_chk(8'h5C);
      read_chk(8'h5C);
      $display("test fixed pointer finished");
      run(1'b0, 1'b0, 1'b1, 8'h85, 8'h77);
      wait_wr(2);
      chk("reg 5", 8'h77, regs[5]);
      chk("pointer", 8'h06, {4'h0, rd_addr});
      read_chk(8'hA6);
      chk("pointer", 8'h07, {4'h0, rd_addr});
      run(1'b0, 1'b0, 1'b0, 8'h0F, 8'h00);
      read_chk(8'hAF);
      run(1'b0, 1'b0, 1'b1, 8'h8F, 8'h3C);
      wait_wr(3);
      chk("reg 15", 8'h3C, regs[15]);
      chk("pointer wrap", 8'h00, {4'h0, rd_addr});
      $display("test auto increment finished");
      run(1'b1, 1'b0, 1'b1, 8'h02, 8'h9A);
      wait_wr(4);
      chk("reg 2", 8'h9A, regs[2]);
      chk("spi mode", 8'h01, {7'h00, spi_mode});
      run(1'b1, 1'b0, 1'b1, 8'h88, 8'h44);
      wait_wr(5);
      chk("reg 8", 8'h44, regs[8]);
      chk("pointer", 8'h09, {4'h0, rd_addr});
      run(1'b1, 1'b0, 1'b0, 8'h0C, 8'h00);
      chk("pointer", 8'h0C, {4'h0, rd_addr});
      $display("test spi writes finished");
      run(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
      chk("read nack", 8'h01, {7'h00, nack});
      run(1'b0, 1'b0, 1'b1, 8'h01, 8'hEE);
      chk("write nack", 8'h01, {7'h00, nack});
      wait_wr(5);
      $display("test two-wire after spi finished");
      give_verdict();
   end
endmodule : testbench
